// >>> logic/pgh_override.sv
// Port G / Port H pin override logic with an AXI4-Lite register slave.
// Assumes peripheral signals come from logic on aclk; pad inputs are asynchronous.
`timescale 1ns/1ps

// Operation
// - G5 output value comes from timer0 compare-B when its output is enabled.
// - Async select detaches G4 from the port as oscillator input.
// - Async select with external clock detaches G3 from the port as oscillator output.
// - G4 forced pull-up off, input, input enable equals external-clock bit.
// - G3 forced pull-up off, input, input disabled when async and external clock.
// - External memory forces G2..G0 to outputs carrying ALE, read, write strobes.
// - H7 feeds the timer4 external count clock input.
// - H6 output value comes from timer2 compare-B when enabled.
// - H5 output value comes from timer4 compare-C when enabled.
// - H4 output value comes from timer4 compare-B when enabled.
// - H3 output value comes from timer4 compare-A when enabled.
// - H2 carries serial clock in sync mode; direction bit picks output or input.
// - H1 carries serial transmit data, H0 serial receive data.
// - Receiver enable forces H0 input; pull-up from port bit unless globally disabled.
// - Transmitter enable forces H1 output, pull-up off, value from transmit data.
module pgh_override (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic timer0_compare_b_enable,
   input wire logic timer0_compare_b_out,
   input wire logic timer2_compare_b_enable,
   input wire logic timer2_compare_b_out,
   input wire logic timer4_compare_a_enable,
   input wire logic timer4_compare_a_out,
   input wire logic timer4_compare_b_enable,
   input wire logic timer4_compare_b_out,
   input wire logic timer4_compare_c_enable,
   input wire logic timer4_compare_c_out,
   input wire logic ext_mem_addr_latch,
   input wire logic ext_mem_read_strobe,
   input wire logic ext_mem_write_strobe,
   input wire logic serial2_sync_mode,
   input wire logic serial2_clock_out,
   input wire logic serial2_tx_enable,
   input wire logic serial2_tx_data,
   input wire logic serial2_rx_enable,
   input wire logic [pgh_pkg::PGH_G_WIDTH-1:0] pad_g_in,
   output logic [pgh_pkg::PGH_G_WIDTH-1:0] pad_g_out,
   output logic [pgh_pkg::PGH_G_WIDTH-1:0] pad_g_oe,
   output logic [pgh_pkg::PGH_G_WIDTH-1:0] pad_g_pullup,
   input wire logic [pgh_pkg::PGH_H_WIDTH-1:0] pad_h_in,
   output logic [pgh_pkg::PGH_H_WIDTH-1:0] pad_h_out,
   output logic [pgh_pkg::PGH_H_WIDTH-1:0] pad_h_oe,
   output logic [pgh_pkg::PGH_H_WIDTH-1:0] pad_h_pullup,
   output logic timer2_osc_attached,
   output logic timer4_count_clock_in,
   output logic serial2_ext_clock_in,
   output logic serial2_rx_data
);
   import pgh_pkg::*;

   function automatic logic [2:0] pgh_decode(input logic [31:0] addr);
      case (addr)
         PGH_OFS_G_PORT: pgh_decode = PGH_IDX_G_PORT;
         PGH_OFS_G_DIR: pgh_decode = PGH_IDX_G_DIR;
         PGH_OFS_G_PIN: pgh_decode = PGH_IDX_G_PIN;
         PGH_OFS_H_PORT: pgh_decode = PGH_IDX_H_PORT;
         PGH_OFS_H_DIR: pgh_decode = PGH_IDX_H_DIR;
         PGH_OFS_H_PIN: pgh_decode = PGH_IDX_H_PIN;
         PGH_OFS_CTRL: pgh_decode = PGH_IDX_CTRL;
         default: pgh_decode = PGH_IDX_NONE;
      endcase
   endfunction

   logic [PGH_G_WIDTH-1:0] g_port;
   logic [PGH_G_WIDTH-1:0] pin_g5_direction_vec;
   logic [PGH_H_WIDTH-1:0] h_port;
   logic [PGH_H_WIDTH-1:0] h_dir;
   logic [PGH_CTRL_WIDTH-1:0] async_status_reg;
   logic global_pullup_disable;
   logic timer2_async_select;
   logic ext_clock_input_select;
   logic ext_mem_enable;

   assign global_pullup_disable = async_status_reg[PGH_CTRL_PULLUP_DISABLE];
   assign timer2_async_select = async_status_reg[PGH_CTRL_ASYNC_SELECT];
   assign ext_clock_input_select = async_status_reg[PGH_CTRL_EXT_CLOCK];
   assign ext_mem_enable = async_status_reg[PGH_CTRL_EXT_MEM];

   // Bus write path: address and data latched independently
   logic aw_held;
   logic w_held;
   logic [31:0] awaddr_q;
   logic [31:0] wdata_q;
   logic wstrb0_q;
   logic do_write;
   logic [2:0] wr_idx;

   assign do_write = aw_held & w_held & ~s_axi_bvalid;
   assign wr_idx = pgh_decode(awaddr_q);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         s_axi_awready <= 1'b0;
         awaddr_q <= 32'h0000_0000;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_held <= 1'b1;
         s_axi_awready <= 1'b0;
         awaddr_q <= s_axi_awaddr;
      end else if (do_write) begin
         aw_held <= 1'b0;
      end else if (!aw_held && (!s_axi_bvalid || s_axi_bready)) begin
         s_axi_awready <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held <= 1'b0;
         s_axi_wready <= 1'b0;
         wdata_q <= 32'h0000_0000;
         wstrb0_q <= 1'b0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_held <= 1'b1;
         s_axi_wready <= 1'b0;
         wdata_q <= s_axi_wdata;
         wstrb0_q <= s_axi_wstrb[0];
      end else if (do_write) begin
         w_held <= 1'b0;
      end else if (!w_held && (!s_axi_bvalid || s_axi_bready)) begin
         s_axi_wready <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= PGH_RESP_OKAY;
      end else if (do_write) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= (wr_idx == PGH_IDX_NONE) ? PGH_RESP_DECERR : PGH_RESP_OKAY;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // All fields live in byte lane 0; pin registers ignore writes
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         g_port <= PGH_G_RESET;
         pin_g5_direction_vec <= PGH_G_RESET;
         h_port <= PGH_H_RESET;
         h_dir <= PGH_H_RESET;
         async_status_reg <= PGH_CTRL_RESET;
      end else if (do_write && wstrb0_q) begin
         case (wr_idx)
            PGH_IDX_G_PORT: g_port <= wdata_q[PGH_G_WIDTH-1:0];
            PGH_IDX_G_DIR: pin_g5_direction_vec <= wdata_q[PGH_G_WIDTH-1:0];
            PGH_IDX_H_PORT: h_port <= wdata_q[PGH_H_WIDTH-1:0];
            PGH_IDX_H_DIR: h_dir <= wdata_q[PGH_H_WIDTH-1:0];
            PGH_IDX_CTRL: async_status_reg <= wdata_q[PGH_CTRL_WIDTH-1:0];
            default: ;
         endcase
      end
   end

   // Pad input synchronisers: value accepted once stages two and three agree
   logic [PGH_G_WIDTH-1:0] g_sync [PGH_SYNC_STAGES];
   logic [PGH_H_WIDTH-1:0] h_sync [PGH_SYNC_STAGES];
   logic [PGH_G_WIDTH-1:0] g_pin_q;
   logic [PGH_H_WIDTH-1:0] h_pin_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         // Receive line idles high; a low reset value would fake a start bit
         for (int i = 0; i < PGH_SYNC_STAGES; i++) begin
            g_sync[i] <= PGH_G_RESET;
            h_sync[i] <= PGH_H_RESET | PGH_H_WIDTH'(1 << PGH_H_RXD);
         end
         g_pin_q <= PGH_G_RESET;
         h_pin_q <= PGH_H_RESET | PGH_H_WIDTH'(1 << PGH_H_RXD);
      end else begin
         g_sync[0] <= pad_g_in;
         h_sync[0] <= pad_h_in;
         for (int i = 1; i < PGH_SYNC_STAGES; i++) begin
            g_sync[i] <= g_sync[i-1];
            h_sync[i] <= h_sync[i-1];
         end
         g_pin_q <= (g_sync[1] & g_sync[2]) | (g_pin_q & (g_sync[1] ^ g_sync[2]));
         h_pin_q <= (h_sync[1] & h_sync[2]) | (h_pin_q & (h_sync[1] ^ h_sync[2]));
      end
   end

   // Override signals, Port G
   logic [PGH_G_WIDTH-1:0] g_pullup_override_enable;
   logic [PGH_G_WIDTH-1:0] g_pullup_override_value;
   logic [PGH_G_WIDTH-1:0] g_direction_override_enable;
   logic [PGH_G_WIDTH-1:0] g_direction_override_value;
   logic [PGH_G_WIDTH-1:0] g_output_value_override_enable;
   logic [PGH_G_WIDTH-1:0] g_output_value_override_value;
   logic [PGH_G_WIDTH-1:0] g_input_enable_override_enable;
   logic [PGH_G_WIDTH-1:0] g_input_enable_override_value;
   logic osc_out_claimed;

   assign osc_out_claimed = timer2_async_select & ext_clock_input_select;

   always_comb begin
      g_pullup_override_enable = '0;
      g_pullup_override_value = '0;
      g_direction_override_enable = '0;
      g_direction_override_value = '0;
      g_output_value_override_enable = '0;
      g_output_value_override_value = '0;
      g_input_enable_override_enable = '0;
      g_input_enable_override_value = '0;
      g_output_value_override_enable[PGH_G_CMP] = timer0_compare_b_enable;
      g_output_value_override_value[PGH_G_CMP] = timer0_compare_b_out;
      g_pullup_override_enable[PGH_G_OSC_IN] = timer2_async_select;
      g_direction_override_enable[PGH_G_OSC_IN] = timer2_async_select;
      g_input_enable_override_enable[PGH_G_OSC_IN] = timer2_async_select;
      g_input_enable_override_value[PGH_G_OSC_IN] = ext_clock_input_select;
      g_pullup_override_enable[PGH_G_OSC_OUT] = osc_out_claimed;
      g_direction_override_enable[PGH_G_OSC_OUT] = osc_out_claimed;
      g_input_enable_override_enable[PGH_G_OSC_OUT] = osc_out_claimed;
      for (int i = PGH_G_WR; i <= PGH_G_ALE; i++) begin
         g_pullup_override_enable[i] = ext_mem_enable;
         g_direction_override_enable[i] = ext_mem_enable;
         g_direction_override_value[i] = 1'b1;
         g_output_value_override_enable[i] = ext_mem_enable;
      end
      g_output_value_override_value[PGH_G_ALE] = ext_mem_addr_latch;
      g_output_value_override_value[PGH_G_RD] = ext_mem_read_strobe;
      g_output_value_override_value[PGH_G_WR] = ext_mem_write_strobe;
   end

   // Override signals, Port H
   logic [PGH_H_WIDTH-1:0] h_pullup_override_enable;
   logic [PGH_H_WIDTH-1:0] h_pullup_override_value;
   logic [PGH_H_WIDTH-1:0] h_direction_override_enable;
   logic [PGH_H_WIDTH-1:0] h_direction_override_value;
   logic [PGH_H_WIDTH-1:0] h_output_value_override_enable;
   logic [PGH_H_WIDTH-1:0] h_output_value_override_value;
   logic xck_drives;

   // Clock is driven only in sync mode with the direction bit set
   assign xck_drives = serial2_sync_mode & h_dir[PGH_H_XCK];

   always_comb begin
      h_pullup_override_enable = '0;
      h_pullup_override_value = '0;
      h_direction_override_enable = '0;
      h_direction_override_value = '0;
      h_output_value_override_enable = '0;
      h_output_value_override_value = '0;
      h_output_value_override_enable[PGH_H_T2B] = timer2_compare_b_enable;
      h_output_value_override_value[PGH_H_T2B] = timer2_compare_b_out;
      h_output_value_override_enable[PGH_H_T4C] = timer4_compare_c_enable;
      h_output_value_override_value[PGH_H_T4C] = timer4_compare_c_out;
      h_output_value_override_enable[PGH_H_T4B] = timer4_compare_b_enable;
      h_output_value_override_value[PGH_H_T4B] = timer4_compare_b_out;
      h_output_value_override_enable[PGH_H_T4A] = timer4_compare_a_enable;
      h_output_value_override_value[PGH_H_T4A] = timer4_compare_a_out;
      h_direction_override_enable[PGH_H_XCK] = xck_drives;
      h_direction_override_value[PGH_H_XCK] = 1'b1;
      h_output_value_override_enable[PGH_H_XCK] = xck_drives;
      h_output_value_override_value[PGH_H_XCK] = serial2_clock_out;
      h_pullup_override_enable[PGH_H_TXD] = serial2_tx_enable;
      h_direction_override_enable[PGH_H_TXD] = serial2_tx_enable;
      h_direction_override_value[PGH_H_TXD] = 1'b1;
      h_output_value_override_enable[PGH_H_TXD] = serial2_tx_enable;
      h_output_value_override_value[PGH_H_TXD] = serial2_tx_data;
      h_pullup_override_enable[PGH_H_RXD] = serial2_rx_enable;
      h_pullup_override_value[PGH_H_RXD] = h_port[PGH_H_RXD] & ~global_pullup_disable;
      h_direction_override_enable[PGH_H_RXD] = serial2_rx_enable;
   end

   // Per-pin merge of overrides with port registers
   logic [PGH_G_WIDTH-1:0] next_g_out;
   logic [PGH_G_WIDTH-1:0] next_g_oe;
   logic [PGH_G_WIDTH-1:0] next_g_pullup;
   logic [PGH_G_WIDTH-1:0] g_input_enable;
   logic [PGH_H_WIDTH-1:0] next_h_out;
   logic [PGH_H_WIDTH-1:0] next_h_oe;
   logic [PGH_H_WIDTH-1:0] next_h_pullup;

   for (genvar i = 0; i < PGH_G_WIDTH; i++) begin : g_merge
      assign next_g_oe[i] = g_direction_override_enable[i] ?
         g_direction_override_value[i] : pin_g5_direction_vec[i];
      assign next_g_out[i] = g_output_value_override_enable[i] ?
         g_output_value_override_value[i] : g_port[i];
      assign next_g_pullup[i] = g_pullup_override_enable[i] ? g_pullup_override_value[i] :
         (g_port[i] & ~pin_g5_direction_vec[i] & ~global_pullup_disable);
      assign g_input_enable[i] = g_input_enable_override_enable[i] ?
         g_input_enable_override_value[i] : 1'b1;
   end

   for (genvar i = 0; i < PGH_H_WIDTH; i++) begin : h_merge
      assign next_h_oe[i] = h_direction_override_enable[i] ?
         h_direction_override_value[i] : h_dir[i];
      assign next_h_out[i] = h_output_value_override_enable[i] ?
         h_output_value_override_value[i] : h_port[i];
      assign next_h_pullup[i] = h_pullup_override_enable[i] ? h_pullup_override_value[i] :
         (h_port[i] & ~h_dir[i] & ~global_pullup_disable);
   end

   // Pad and peripheral outputs registered; adds one cycle to every override path except the Port G input-enable gate on pin reads
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pad_g_out <= PGH_G_RESET;
         pad_g_oe <= PGH_G_RESET;
         pad_g_pullup <= PGH_G_RESET;
         pad_h_out <= PGH_H_RESET;
         pad_h_oe <= PGH_H_RESET;
         pad_h_pullup <= PGH_H_RESET;
      end else begin
         pad_g_out <= next_g_out;
         pad_g_oe <= next_g_oe;
         pad_g_pullup <= next_g_pullup;
         pad_h_out <= next_h_out;
         pad_h_oe <= next_h_oe;
         pad_h_pullup <= next_h_pullup;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         timer2_osc_attached <= 1'b0;
         timer4_count_clock_in <= 1'b0;
         serial2_ext_clock_in <= 1'b0;
         serial2_rx_data <= 1'b1;
      end else begin
         timer2_osc_attached <= timer2_async_select;
         timer4_count_clock_in <= h_pin_q[PGH_H_T4CLK];
         serial2_ext_clock_in <= h_pin_q[PGH_H_XCK] & serial2_sync_mode;
         serial2_rx_data <= h_pin_q[PGH_H_RXD];
      end
   end

   // Read path: one-cycle answer
   logic [31:0] rd_word;
   always_comb begin
      rd_word = 32'h0000_0000;
      case (pgh_decode(s_axi_araddr))
         PGH_IDX_G_PORT: rd_word[PGH_G_WIDTH-1:0] = g_port;
         PGH_IDX_G_DIR: rd_word[PGH_G_WIDTH-1:0] = pin_g5_direction_vec;
         PGH_IDX_G_PIN: rd_word[PGH_G_WIDTH-1:0] = g_pin_q & g_input_enable;
         PGH_IDX_H_PORT: rd_word[PGH_H_WIDTH-1:0] = h_port;
         PGH_IDX_H_DIR: rd_word[PGH_H_WIDTH-1:0] = h_dir;
         PGH_IDX_H_PIN: rd_word[PGH_H_WIDTH-1:0] = h_pin_q;
         PGH_IDX_CTRL: rd_word[PGH_CTRL_WIDTH-1:0] = async_status_reg;
         default: rd_word = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= PGH_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_word;
         s_axi_rresp <= (pgh_decode(s_axi_araddr) == PGH_IDX_NONE) ?
            PGH_RESP_DECERR : PGH_RESP_OKAY;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end else if (!s_axi_rvalid) begin
         s_axi_arready <= 1'b1;
      end
   end
endmodule // pgh_override

// >>> logic/pgh_pkg.sv
// Constants for the Port G / Port H alternate-function override block.
// Assumes an AXI4-Lite register slave with 32-bit data and byte addresses.
package pgh_pkg;
   localparam int PGH_G_WIDTH = 6;
   localparam int PGH_H_WIDTH = 8;
   localparam int PGH_SYNC_STAGES = 3;

   // Register byte offsets
   localparam logic [31:0] PGH_OFS_G_PORT = 32'h0000_0000;
   localparam logic [31:0] PGH_OFS_G_DIR = 32'h0000_0004;
   localparam logic [31:0] PGH_OFS_G_PIN = 32'h0000_0008;
   localparam logic [31:0] PGH_OFS_H_PORT = 32'h0000_000C;
   localparam logic [31:0] PGH_OFS_H_DIR = 32'h0000_0010;
   localparam logic [31:0] PGH_OFS_H_PIN = 32'h0000_0014;
   localparam logic [31:0] PGH_OFS_CTRL = 32'h0000_0018;

   // Register decode indices
   localparam logic [2:0] PGH_IDX_G_PORT = 3'h0;
   localparam logic [2:0] PGH_IDX_G_DIR = 3'h1;
   localparam logic [2:0] PGH_IDX_G_PIN = 3'h2;
   localparam logic [2:0] PGH_IDX_H_PORT = 3'h3;
   localparam logic [2:0] PGH_IDX_H_DIR = 3'h4;
   localparam logic [2:0] PGH_IDX_H_PIN = 3'h5;
   localparam logic [2:0] PGH_IDX_CTRL = 3'h6;
   localparam logic [2:0] PGH_IDX_NONE = 3'h7;

   // Control register fields
   localparam int PGH_CTRL_PULLUP_DISABLE = 0;
   localparam int PGH_CTRL_ASYNC_SELECT = 1;
   localparam int PGH_CTRL_EXT_CLOCK = 2;
   localparam int PGH_CTRL_EXT_MEM = 3;
   localparam int PGH_CTRL_WIDTH = 4;

   // Reset values
   localparam logic [5:0] PGH_G_RESET = 6'h00;
   localparam logic [7:0] PGH_H_RESET = 8'h00;
   localparam logic [3:0] PGH_CTRL_RESET = 4'h0;

   // Pin positions, Port G
   localparam int PGH_G_WR = 0;
   localparam int PGH_G_RD = 1;
   localparam int PGH_G_ALE = 2;
   localparam int PGH_G_OSC_OUT = 3;
   localparam int PGH_G_OSC_IN = 4;
   localparam int PGH_G_CMP = 5;

   // Pin positions, Port H
   localparam int PGH_H_RXD = 0;
   localparam int PGH_H_TXD = 1;
   localparam int PGH_H_XCK = 2;
   localparam int PGH_H_T4A = 3;
   localparam int PGH_H_T4B = 4;
   localparam int PGH_H_T4C = 5;
   localparam int PGH_H_T2B = 6;
   localparam int PGH_H_T4CLK = 7;

   // AXI responses
   localparam logic [1:0] PGH_RESP_OKAY = 2'h0;
   localparam logic [1:0] PGH_RESP_DECERR = 2'h3;
endpackage

// >>> test/pgh_override_props.sv
// Concurrent checks on the pin override block, bound to its ports.
// Assumes one clock, aclk, with synchronous active-low aresetn.
`timescale 1ns/1ps
module pgh_override_props (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic timer0_compare_b_enable,
   input wire logic timer0_compare_b_out,
   input wire logic timer2_compare_b_enable,
   input wire logic timer2_compare_b_out,
   input wire logic serial2_tx_enable,
   input wire logic serial2_tx_data,
   input wire logic serial2_rx_enable,
   input wire logic serial2_sync_mode,
   input wire logic [pgh_pkg::PGH_G_WIDTH-1:0] pad_g_out,
   input wire logic [pgh_pkg::PGH_G_WIDTH-1:0] pad_g_oe,
   input wire logic [pgh_pkg::PGH_G_WIDTH-1:0] pad_g_pullup,
   input wire logic [pgh_pkg::PGH_H_WIDTH-1:0] pad_h_in,
   input wire logic [pgh_pkg::PGH_H_WIDTH-1:0] pad_h_out,
   input wire logic [pgh_pkg::PGH_H_WIDTH-1:0] pad_h_oe,
   input wire logic [pgh_pkg::PGH_H_WIDTH-1:0] pad_h_pullup,
   input wire logic timer2_osc_attached,
   input wire logic timer4_count_clock_in,
   input wire logic serial2_ext_clock_in
);
   import pgh_pkg::*;
   logic [3:0] up;
   // Checks wait until reset values have drained out of the sync chains
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         up <= 4'h0;
      end else if (!up[3]) begin
         up <= up + 4'h1;
      end
   end
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   a_g5_cmp_drive: assert property (up[3] && timer0_compare_b_enable
      |=> pad_g_out[PGH_G_CMP] == $past(timer0_compare_b_out)) else $error("G5 value wrong");
   a_h6_cmp_drive: assert property (up[3] && timer2_compare_b_enable
      |=> pad_h_out[PGH_H_T2B] == $past(timer2_compare_b_out)) else $error("H6 value wrong");
   a_osc_g4_detach: assert property ((up[3] && timer2_osc_attached)[*3]
      |-> !pad_g_oe[PGH_G_OSC_IN] && !pad_g_pullup[PGH_G_OSC_IN]) else $error("G4 not detached");
   a_tx_pin_force: assert property (up[3] && serial2_tx_enable |=> pad_h_oe[PGH_H_TXD]
      && !pad_h_pullup[PGH_H_TXD] && pad_h_out[PGH_H_TXD] == $past(serial2_tx_data))
      else $error("H1 not forced");
   a_rx_pin_input: assert property (up[3] && serial2_rx_enable
      |=> !pad_h_oe[PGH_H_RXD]) else $error("H0 driven");
   a_xck_sync_gate: assert property ((up[3] && !serial2_sync_mode)[*2]
      |=> !serial2_ext_clock_in) else $error("serial clock passed outside sync mode");
   a_t4_clk_sync: assert property ((up[3] && $stable(pad_h_in[PGH_H_T4CLK]))[*7]
      |-> timer4_count_clock_in == pad_h_in[PGH_H_T4CLK]) else $error("count clock wrong");
   a_no_pull_drive: assert property (up[3] |-> (pad_g_oe & pad_g_pullup) == 6'h00
      && (pad_h_oe & pad_h_pullup) == 8'h00) else $error("pull-up on a driven pin");
endmodule // pgh_override_props

// >>> test/pgh_override_test.sv
// Self-checking bench for the pin override block and its register slave.
// Assumes the partner model drives all peripheral inputs through sig.
`timescale 1ns/1ps
module pgh_override_test;
   import pgh_pkg::*;
   typedef struct packed {
      logic [3:0] ctrl;
      logic [17:0] per;
      logic [5:0] gp, gd, goe, gout, gpu;
      logic [7:0] hp, hd, hoe, hout, hpu;
   } pgh_row_t;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   // Ready lines stay high: every answer is taken at the edge it shows
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b1;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b1;
   logic [31:0] s_axi_awaddr = 32'h0000_0000, s_axi_wdata = 32'h0000_0000;
   logic [31:0] s_axi_araddr = 32'h0000_0000, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic [PGH_G_WIDTH-1:0] pad_g_in = 6'h3F, pad_g_out, pad_g_oe, pad_g_pullup;
   logic [PGH_H_WIDTH-1:0] pad_h_in = 8'h81, pad_h_out, pad_h_oe, pad_h_pullup;
   logic [17:0] cmd = 18'h0_0000, sig;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic timer2_osc_attached, timer4_count_clock_in, serial2_ext_clock_in, serial2_rx_data;
   logic serial2_rx_enable, serial2_tx_enable, serial2_tx_data, serial2_sync_mode;
   logic serial2_clock_out, ext_mem_write_strobe, ext_mem_read_strobe, ext_mem_addr_latch;
   logic timer4_compare_c_enable, timer4_compare_c_out, timer4_compare_b_enable;
   logic timer4_compare_b_out, timer4_compare_a_enable, timer4_compare_a_out;
   logic timer2_compare_b_enable, timer2_compare_b_out, timer0_compare_b_enable;
   logic timer0_compare_b_out;
   int n_errors = 0;
   int cmp_count = 0;
   pgh_row_t rows [6] = '{
      '{4'h0, 18'h0_0000, 6'h2A, 6'h0F, 6'h0F, 6'h2A, 6'h20, 8'hA5, 8'h0F, 8'h0F, 8'hA5, 8'hA0},
      '{4'h8, 18'h0_16EF, 6'h02, 6'h20, 6'h27, 6'h25, 6'h00, 8'h08, 8'h78, 8'h78, 8'h50, 8'h00},
      '{4'h6, 18'h0_0000, 6'h18, 6'h00, 6'h00, 6'h18, 6'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00},
      '{4'h2, 18'h0_0000, 6'h18, 6'h18, 6'h08, 6'h18, 6'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00},
      '{4'h0, 18'h3_E000, 6'h00, 6'h00, 6'h00, 6'h00, 6'h00, 8'h01, 8'h05, 8'h06, 8'h07, 8'h01},
      '{4'h1, 18'h3_4000, 6'h00, 6'h00, 6'h00, 6'h00, 6'h00, 8'h01, 8'h05, 8'h06, 8'h01, 8'h00}};
   assign {serial2_rx_enable, serial2_tx_enable, serial2_tx_data, serial2_sync_mode,
      serial2_clock_out, ext_mem_write_strobe, ext_mem_read_strobe, ext_mem_addr_latch,
      timer4_compare_c_enable, timer4_compare_c_out, timer4_compare_b_enable,
      timer4_compare_b_out, timer4_compare_a_enable, timer4_compare_a_out,
      timer2_compare_b_enable, timer2_compare_b_out, timer0_compare_b_enable,
      timer0_compare_b_out} = sig;
`define CHK(a, e) \
   begin \
      cmp_count++; \
      if ((a) !== (e)) begin \
         n_errors++; \
         $display("unexpected at %0t: got %h want %h", $time, (a), (e)); \
      end \
   end
   always #5 aclk = ~aclk;
   pgh_periph_model i_pgh_periph_model (.aclk(aclk), .aresetn(aresetn), .cmd(cmd), .sig(sig));
   pgh_override i_pgh_override (.*);
   task automatic stop_test;
      $display("comparisons %0d, mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic tmo(input int n);
      if (n >= 40) begin
         n_errors++;
         stop_test();
      end
   endtask
   task automatic axw(input logic [31:0] a, input logic [31:0] d, input logic [1:0] r);
      int n;
      n = 0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid && n < 40);
      tmo(n);
      `CHK(s_axi_bresp, r)
   endtask
   task automatic axr(input logic [31:0] a, input logic [31:0] e, input logic [1:0] r);
      int n;
      n = 0;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid && n < 40);
      tmo(n);
      `CHK(s_axi_rdata, e)
      `CHK(s_axi_rresp, r)
   endtask
   initial begin
      repeat (5) @(posedge aclk);
      `CHK(pad_h_oe, 8'h00)
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      axr(PGH_OFS_CTRL, 32'h0000_0000, PGH_RESP_OKAY);
      axr(32'h0000_001C, 32'h0000_0000, PGH_RESP_DECERR);
      axw(32'h0000_0020, 32'h0000_00FF, PGH_RESP_DECERR);
      axw(PGH_OFS_G_PIN, 32'h0000_0000, PGH_RESP_OKAY);
      axr(PGH_OFS_G_PIN, 32'h0000_003F, PGH_RESP_OKAY);
      s_axi_wstrb <= 4'h0;
      axw(PGH_OFS_CTRL, 32'h0000_000F, PGH_RESP_OKAY);
      s_axi_wstrb <= 4'hF;
      axr(PGH_OFS_CTRL, 32'h0000_0000, PGH_RESP_OKAY);
      $display("reset and map test done");
      foreach (rows[i]) begin
         axw(PGH_OFS_CTRL, 32'(rows[i].ctrl), PGH_RESP_OKAY);
         axw(PGH_OFS_G_PORT, 32'(rows[i].gp), PGH_RESP_OKAY);
         axw(PGH_OFS_G_DIR, 32'(rows[i].gd), PGH_RESP_OKAY);
         axw(PGH_OFS_H_PORT, 32'(rows[i].hp), PGH_RESP_OKAY);
         axw(PGH_OFS_H_DIR, 32'(rows[i].hd), PGH_RESP_OKAY);
         cmd <= rows[i].per;
         repeat (4) @(posedge aclk);
         `CHK(pad_g_oe, rows[i].goe)
         `CHK(pad_g_out, rows[i].gout)
         `CHK(pad_g_pullup, rows[i].gpu)
         `CHK(pad_h_oe, rows[i].hoe)
         `CHK(pad_h_out, rows[i].hout)
         `CHK(pad_h_pullup, rows[i].hpu)
         $display("row %0d done", i);
      end
      axw(PGH_OFS_CTRL, 32'h0000_0002, PGH_RESP_OKAY);
      repeat (3) @(posedge aclk);
      `CHK(timer2_osc_attached, 1'b1)
      axr(PGH_OFS_G_PIN, 32'h0000_002F, PGH_RESP_OKAY);
      axw(PGH_OFS_CTRL, 32'h0000_0006, PGH_RESP_OKAY);
      repeat (3) @(posedge aclk);
      axr(PGH_OFS_G_PIN, 32'h0000_0037, PGH_RESP_OKAY);
      $display("oscillator input test done");
      pad_h_in <= 8'h5E;
      repeat (6) @(posedge aclk);
      `CHK(timer4_count_clock_in, 1'b0)
      `CHK(serial2_rx_data, 1'b0)
      `CHK(serial2_ext_clock_in, 1'b1)
      axr(PGH_OFS_H_PIN, 32'h0000_005E, PGH_RESP_OKAY);
      cmd <= 18'h0_0000;
      repeat (3) @(posedge aclk);
      `CHK(serial2_ext_clock_in, 1'b0)
      $display("input sync test done");
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (3) @(posedge aclk);
      `CHK(pad_h_oe, 8'h00)
      `CHK(serial2_rx_data, 1'b1)
      axr(PGH_OFS_H_DIR, 32'h0000_0000, PGH_RESP_OKAY);
      $display("mid-run reset test done");
      stop_test();
   end
endmodule // pgh_override_test
bind pgh_override pgh_override_props i_pgh_override_props (.*);

// >>> test/pgh_periph_model.sv
// Stand-in for the timers, serial unit and memory interface beside the pins.
// Assumes cmd comes from the bench on aclk; outputs are registered levels.
`timescale 1ns/1ps
module pgh_periph_model (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [17:0] cmd,
   output logic [17:0] sig
);
   // Peripherals drive from flops, so a change shows one edge late
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sig <= 18'h0_0000;
      end else begin
         sig <= cmd;
      end
   end
endmodule // pgh_periph_model
